// file: hdl/gpgi_pkg.sv
// Purpose: constants for the ganged-output port and pin interrupt block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: offsets are byte addresses
package gpgi_pkg;
  localparam int unsigned NPINS = 8;
  localparam int unsigned NPORTS = 3;
  localparam logic [7:0] ADDR_W = 8'h40;
  // per port x at base x*0x10; drive, peripheral enable and analog enable at their own base + x*4
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_PULL = 8'h08;
  localparam logic [7:0] OFF_SLEW = 8'h0C;
  localparam logic [7:0] OFF_DRIVE = 8'h10 - 8'h10 + 8'h30;
  localparam logic [7:0] ADDR_PERIPH_BASE = 8'h40;
  localparam logic [7:0] ADDR_GANG = 8'h80;
  localparam logic [7:0] ADDR_IRQ_SC_A = 8'h84;
  localparam logic [7:0] ADDR_IRQ_EN_A = 8'h88;
  localparam logic [7:0] ADDR_IRQ_POL_A = 8'h8C;
  localparam logic [7:0] ADDR_IRQ_SC_B = 8'h90;
  localparam logic [7:0] ADDR_IRQ_EN_B = 8'h94;
  localparam logic [7:0] ADDR_IRQ_POL_B = 8'h98;
  localparam logic [7:0] ADDR_ANALOG_BASE = 8'hA0;
  // status/control field positions
  localparam int unsigned SC_FLAG = 3;
  localparam int unsigned SC_ACK = 2;
  localparam int unsigned SC_IE = 1;
  localparam int unsigned SC_MODE = 0;
  // gang control field positions
  localparam int unsigned GANG_EN = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // port indices
  localparam int unsigned PORT_A = 0;
  localparam int unsigned PORT_B = 1;
  localparam int unsigned PORT_C = 2;
endpackage

// file: hdl/gpgi_port.sv
// Purpose: three 8-bit parallel ports with pin control, ganged output and pin interrupts
// Assumes: pin inputs synchronous to clk_sys_i; registers over AHB-Lite, zero wait states
// Notes: peripheral and analog enables come from registers, peripheral signals from ports
// What this block does
// [RQ1] direction bit enables driver and selects data read source
// [RQ2] input buffer enabled unless pin is analog
// [RQ3] enabled peripheral drives pin; direction still selects read source
// [RQ4] analog disables both buffers, beats digital; input reads return zero
// [RQ5] per-pin pull enable, off when output, peripheral output or analog
// [RQ6] per-pin slew and drive bits, independent of data and direction
// [RQ7] write-once gang register: one enable, seven select bits
// [RQ8] selects 7..4 map to B5..B2, 3..1 to C3..C1, enable to C0
// [RQ9] selected gang pins output with C0 data, drive and slew
// [RQ10] gang enable forces C0 to output
// [RQ11] gang beats digital peripheral; analog beats gang
// [RQ12] interrupts and wake on A3..A0 and B3..B0
// [RQ13] each pin interrupt has its own enable bit
// [RQ14] one mode bit per port: edge only or edge and level
// [RQ15] polarity bit picks falling/low or rising/high
// [RQ16] edges found by comparing successive bus-clock samples
// [RQ17] outside keeps enabled inputs deasserted before an edge
// [RQ18] valid event sets port flag; request raised when enabled
// [RQ19] edge mode: writing one to acknowledge clears the flag
// [RQ20] edge mode: no new edge latched while another enabled pin asserted
// [RQ21] level mode: acknowledge clears only if all enabled inputs deasserted
// [RQ22] direction zero reads pin; one drives and reads latch
// [RQ23] reset: inputs, peripherals off, slew, drive, pull off
// [RQ24] interrupt pin pull is up for polarity zero, down for one
// [RQ25] request is a level while flag and request enable set
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module gpgi_port
  import gpgi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // pins, port-major: [8*p+n]
  input wire logic [23:0] pin_in_i,
  output logic [23:0] pin_out_o,
  output logic [23:0] pin_oe_o,
  output logic [23:0] pin_ie_o,
  output logic [23:0] pin_pullen_o,
  output logic [23:0] pin_pulldn_o,
  output logic [23:0] pin_slew_o,
  output logic [23:0] pin_hidrive_o,
  // shared digital peripherals
  input wire logic [23:0] periph_out_i,
  input wire logic [23:0] periph_oe_i,
  // interrupt requests and wake, port a and b
  output logic irq_a_o,
  output logic irq_b_o,
  output logic wake_o
);

  logic [7:0] data_r [NPORTS];
  logic [7:0] dir_r [NPORTS];
  logic [7:0] pull_r [NPORTS];
  logic [7:0] slew_r [NPORTS];
  logic [7:0] drive_r [NPORTS];
  logic [7:0] periph_en_r [NPORTS];
  logic [7:0] analog_en_r [NPORTS];
  logic [7:0] gang_r;
  logic gang_written_r;
  logic [3:0] irq_en_r [2];
  logic [3:0] irq_pol_r [2];
  logic [1:0] irq_mode_r;
  logic [1:0] irq_ie_r;
  logic [1:0] irq_flag_r;
  logic [3:0] samp_r [2];

  // ahb address phase capture
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic [7:0] rd_addr;
  logic [31:0] rdata_nxt;
  logic ap_valid;

  logic [23:0] gang_sel;
  logic [23:0] ana;
  logic [23:0] drv_oe;
  logic [23:0] drv_out;
  logic [23:0] in_buf;
  logic [3:0] asserted [2];
  logic [3:0] edge_hit [2];
  logic [1:0] ev;
  logic [1:0] ack_w;
  logic [1:0] ack_ok;

  function automatic logic [7:0] port_reg(input logic [7:0] a, input logic [7:0] off);
    port_reg = a - off;
  endfunction

  assign ap_valid = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign hreadyout_o = 1'b1;
  assign hresp_o = HRESP_OKAY;

  // only word writes are taken; narrower writes are dropped rather than half applied
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_pend_r <= 1'b0;
      waddr_r <= RST_BYTE;
    end else begin
      wr_pend_r <= ap_valid && hwrite_i && (hsize_i == HSIZE_WORD);
      waddr_r <= haddr_i[7:0];
    end
  end

  // gang pin map: gang bit k selects pin index
  always_comb begin
    gang_sel = '0;
    if (gang_r[GANG_EN]) begin
      gang_sel[8*PORT_C + 0] = 1'b1; // [RQ8] [RQ10]
      gang_sel[8*PORT_C + 3 -: 3] = gang_r[3:1]; // [RQ8]
      gang_sel[8*PORT_B + 5 -: 4] = gang_r[7:4]; // [RQ8]
    end
  end

  // pin drive priority: analog, gang, peripheral, port
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      for (int n = 0; n < NPINS; n++) begin
        ana[8*p+n] = analog_en_r[p][n];
        if (analog_en_r[p][n]) begin
          drv_oe[8*p+n] = 1'b0; // [RQ4] [RQ11]
          drv_out[8*p+n] = 1'b0;
        end else if (gang_sel[8*p+n]) begin
          drv_oe[8*p+n] = 1'b1; // [RQ9] [RQ10] [RQ11]
          drv_out[8*p+n] = data_r[PORT_C][0];
        end else if (periph_en_r[p][n]) begin
          drv_oe[8*p+n] = periph_oe_i[8*p+n]; // [RQ3]
          drv_out[8*p+n] = periph_out_i[8*p+n];
        end else begin
          drv_oe[8*p+n] = dir_r[p][n]; // [RQ1] [RQ22]
          drv_out[8*p+n] = data_r[p][n];
        end
        pin_slew_o[8*p+n] = gang_sel[8*p+n] ? slew_r[PORT_C][0] : slew_r[p][n]; // [RQ6] [RQ9]
        pin_hidrive_o[8*p+n] = gang_sel[8*p+n] ? drive_r[PORT_C][0] : drive_r[p][n]; // [RQ6]
        pin_pullen_o[8*p+n] = pull_r[p][n] && !drv_oe[8*p+n] && !ana[8*p+n]; // [RQ5]
        // direction follows polarity even while the pull itself is off
        pin_pulldn_o[8*p+n] = (p < 2 && n < 4) ? irq_pol_r[p % 2][n % 4] : 1'b0; // [RQ24]
      end
    end
  end

  assign pin_out_o = drv_out;
  assign pin_oe_o = drv_oe;
  assign pin_ie_o = ~ana; // [RQ2]
  assign in_buf = pin_in_i & ~ana; // [RQ4]

  // interrupt detection on ports a and b, low four pins
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 4; n++) begin
        asserted[p][n] = irq_en_r[p][n] &&
          (in_buf[8*p+n] == irq_pol_r[p][n]); // [RQ13] [RQ15]
        edge_hit[p][n] = irq_en_r[p][n] && (samp_r[p][n] != irq_pol_r[p][n]) &&
          (in_buf[8*p+n] == irq_pol_r[p][n]); // [RQ16]
      end
      ack_w[p] = wr_pend_r && (waddr_r == (p == 0 ? ADDR_IRQ_SC_A : ADDR_IRQ_SC_B)) &&
        hwdata_i[SC_ACK];
      if (irq_mode_r[p]) begin
        ev[p] = (|edge_hit[p]) || (|asserted[p]); // [RQ21]
        ack_ok[p] = ack_w[p] && !(|asserted[p]); // [RQ21]
      end else begin
        // an edge is dropped while another enabled pin already sits asserted
        ev[p] = |(edge_hit[p] & ~{4{|(asserted[p] & ~edge_hit[p])}}); // [RQ20]
        ack_ok[p] = ack_w[p]; // [RQ19]
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      samp_r[0] <= 4'h0;
      samp_r[1] <= 4'h0;
      irq_flag_r <= 2'h0;
    end else begin
      samp_r[0] <= in_buf[3:0]; // [RQ16] [RQ12]
      samp_r[1] <= in_buf[11:8];
      for (int p = 0; p < 2; p++) begin
        // a new event wins over an acknowledge in the same cycle
        if (ev[p]) begin
          irq_flag_r[p] <= 1'b1; // [RQ18]
        end else if (ack_ok[p]) begin
          irq_flag_r[p] <= 1'b0; // [RQ19] [RQ21]
        end
      end
    end
  end

  assign irq_a_o = irq_flag_r[0] && irq_ie_r[0]; // [RQ18] [RQ25]
  assign irq_b_o = irq_flag_r[1] && irq_ie_r[1]; // [RQ25]
  assign wake_o = irq_a_o || irq_b_o; // [RQ12]

  // register writes, one process per group of registers
  // port data and direction
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int p = 0; p < NPORTS; p++) begin
        data_r[p] <= RST_BYTE;
        dir_r[p] <= RST_BYTE; // [RQ23]
      end
    end else if (wr_pend_r) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (waddr_r == 8'(p) * PORT_STRIDE + OFF_DATA) begin
          data_r[p] <= hwdata_i[7:0];
        end
        if (waddr_r == 8'(p) * PORT_STRIDE + OFF_DIR) begin
          dir_r[p] <= hwdata_i[7:0]; // [RQ22]
        end
      end
    end
  end

  // pull, slew and drive stand apart from data and direction
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int p = 0; p < NPORTS; p++) begin
        pull_r[p] <= RST_BYTE; // [RQ23]
        slew_r[p] <= RST_BYTE;
        drive_r[p] <= RST_BYTE;
      end
    end else if (wr_pend_r) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (waddr_r == 8'(p) * PORT_STRIDE + OFF_PULL) begin
          pull_r[p] <= hwdata_i[7:0]; // [RQ5]
        end
        if (waddr_r == 8'(p) * PORT_STRIDE + OFF_SLEW) begin
          slew_r[p] <= hwdata_i[7:0]; // [RQ6]
        end
        if (port_reg(waddr_r, 8'(p) * 8'h04) == OFF_DRIVE) begin
          drive_r[p] <= hwdata_i[7:0]; // [RQ6]
        end
      end
    end
  end

  // function enables; analog is kept apart so it can win over everything
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int p = 0; p < NPORTS; p++) begin
        periph_en_r[p] <= RST_BYTE; // [RQ23]
        analog_en_r[p] <= RST_BYTE;
      end
    end else if (wr_pend_r) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (port_reg(waddr_r, 8'(p) * 8'h04) == ADDR_PERIPH_BASE) begin
          periph_en_r[p] <= hwdata_i[7:0]; // [RQ3]
        end
        if (port_reg(waddr_r, 8'(p) * 8'h04) == ADDR_ANALOG_BASE) begin
          analog_en_r[p] <= hwdata_i[7:0]; // [RQ4]
        end
      end
    end
  end

  // pin interrupt configuration, ports a and b
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int p = 0; p < 2; p++) begin
        irq_en_r[p] <= 4'h0;
        irq_pol_r[p] <= 4'h0;
      end
      irq_mode_r <= 2'h0;
      irq_ie_r <= 2'h0;
    end else if (wr_pend_r) begin
      if (waddr_r == ADDR_IRQ_SC_A) begin
        irq_mode_r[0] <= hwdata_i[SC_MODE]; // [RQ14]
        irq_ie_r[0] <= hwdata_i[SC_IE];
      end
      if (waddr_r == ADDR_IRQ_SC_B) begin
        irq_mode_r[1] <= hwdata_i[SC_MODE];
        irq_ie_r[1] <= hwdata_i[SC_IE];
      end
      if (waddr_r == ADDR_IRQ_EN_A) begin
        irq_en_r[0] <= hwdata_i[3:0]; // [RQ13]
      end
      if (waddr_r == ADDR_IRQ_EN_B) begin
        irq_en_r[1] <= hwdata_i[3:0];
      end
      if (waddr_r == ADDR_IRQ_POL_A) begin
        irq_pol_r[0] <= hwdata_i[3:0]; // [RQ15]
      end
      if (waddr_r == ADDR_IRQ_POL_B) begin
        irq_pol_r[1] <= hwdata_i[3:0];
      end
    end
  end

  // gang control takes only the first write after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      gang_r <= RST_BYTE;
      gang_written_r <= 1'b0;
    end else if (wr_pend_r && waddr_r == ADDR_GANG && !gang_written_r) begin
      gang_r <= hwdata_i[7:0]; // [RQ7]
      gang_written_r <= 1'b1;
    end
  end

  // read mux, registered from the address phase
  assign rd_addr = haddr_i[7:0];
  always_comb begin
    rdata_nxt = '0;
    for (int p = 0; p < NPORTS; p++) begin
      if (rd_addr == 8'(p) * PORT_STRIDE + OFF_DATA)
        rdata_nxt[7:0] = (dir_r[p] & data_r[p]) | (~dir_r[p] & in_buf[8*p +: 8]); // [RQ1] [RQ4] [RQ22]
      if (rd_addr == 8'(p) * PORT_STRIDE + OFF_DIR) rdata_nxt[7:0] = dir_r[p];
      if (rd_addr == 8'(p) * PORT_STRIDE + OFF_PULL) rdata_nxt[7:0] = pull_r[p];
      if (rd_addr == 8'(p) * PORT_STRIDE + OFF_SLEW) rdata_nxt[7:0] = slew_r[p];
      if (port_reg(rd_addr, 8'(p) * 8'h04) == OFF_DRIVE) rdata_nxt[7:0] = drive_r[p];
      if (port_reg(rd_addr, 8'(p) * 8'h04) == ADDR_PERIPH_BASE) rdata_nxt[7:0] = periph_en_r[p];
      if (port_reg(rd_addr, 8'(p) * 8'h04) == ADDR_ANALOG_BASE) rdata_nxt[7:0] = analog_en_r[p];
    end
    if (rd_addr == ADDR_GANG) rdata_nxt[7:0] = gang_r;
    if (rd_addr == ADDR_IRQ_SC_A) rdata_nxt[3:0] = {irq_flag_r[0], 1'b0, irq_ie_r[0], irq_mode_r[0]};
    if (rd_addr == ADDR_IRQ_SC_B) rdata_nxt[3:0] = {irq_flag_r[1], 1'b0, irq_ie_r[1], irq_mode_r[1]};
    if (rd_addr == ADDR_IRQ_EN_A) rdata_nxt[3:0] = irq_en_r[0];
    if (rd_addr == ADDR_IRQ_EN_B) rdata_nxt[3:0] = irq_en_r[1];
    if (rd_addr == ADDR_IRQ_POL_A) rdata_nxt[3:0] = irq_pol_r[0];
    if (rd_addr == ADDR_IRQ_POL_B) rdata_nxt[3:0] = irq_pol_r[1];
  end

  // read data is taken at the address phase and stands until the next read
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hrdata_o <= '0;
    end else if (ap_valid && !hwrite_i) begin
      hrdata_o <= rdata_nxt;
    end
  end

endmodule // gpgi_port

// file: bench/gpgi_port_props.sv
// Purpose: port-level checks of gpgi_port
// Assumes: one clock, synchronous reset
// Notes: register contents are not visible, so causes are taken from bus writes
`timescale 1ns/1ps
module gpgi_port_props
  import gpgi_pkg::*;
(
  // clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // pins and requests
  input wire logic [23:0] pin_in_i,
  input wire logic [23:0] pin_oe_o,
  input wire logic [23:0] pin_ie_o,
  input wire logic [23:0] pin_pullen_o,
  input wire logic [23:0] pin_pulldn_o,
  input wire logic [23:0] pin_slew_o,
  input wire logic [23:0] pin_hidrive_o,
  input wire logic irq_a_o,
  input wire logic irq_b_o,
  input wire logic wake_o
);
  logic [4:1] wr_sh_r;
  logic wr_nxt;
  // bit d holds whether a write address phase was taken d edges back
  assign wr_nxt = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ) & hwrite_i;
  always_ff @(posedge clk_sys_i) begin
    wr_sh_r <= {wr_sh_r[3:1], wr_nxt};
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  AST_BUS_OKAY: assert property (hreadyout_o && hresp_o == HRESP_OKAY)
    else $error("bus answer not ready and okay");
  AST_RESET_STATE: assert property ($past(srst_i) |-> !wake_o && pin_ie_o == 24'hFFFFFF &&
    (pin_oe_o | pin_pullen_o | pin_slew_o | pin_hidrive_o) == 24'h000000)
    else $error("pin state after reset wrong");
  AST_ANALOG_BUFFERS: assert property ((~pin_ie_o & (pin_oe_o | pin_pullen_o)) == 24'h000000)
    else $error("analog pin still driven or pulled");
  AST_PULL_OFF_DRIVEN: assert property ((pin_oe_o & pin_pullen_o) == 24'h000000)
    else $error("pull active on driven pin");
  AST_PULLDN_IRQ_ONLY: assert property ((pin_pulldn_o & 24'hFFF0F0) == 24'h000000)
    else $error("pull down on non-interrupt pin");
  AST_WAKE_LEVEL: assert property (wake_o == (irq_a_o | irq_b_o))
    else $error("wake differs from requests");
  AST_IRQ_RISE_CAUSE: assert property ($rose(wake_o) |-> (|wr_sh_r[3:2]) ||
    $past(pin_in_i & 24'h000F0F) != $past(pin_in_i & 24'h000F0F, 2))
    else $error("request rose without pin event or write");
  AST_IRQ_FALL_CAUSE: assert property ($fell(irq_a_o) |-> |wr_sh_r[3:2])
    else $error("request fell without a write");
endmodule // gpgi_port_props

// file: bench/gpgi_pins_model.sv
// Purpose: external pins: board drivers, pull resistors, floating pins
// Assumes: bench chooses which pins the board drives
// Notes: a pin nobody drives or pulls toggles each cycle so a stale value is never read
`timescale 1ns/1ps
module gpgi_pins_model (
  // clock
  input wire logic clk_sys_i,
  // device side
  input wire logic [23:0] pin_out_i,
  input wire logic [23:0] pin_oe_i,
  input wire logic [23:0] pull_en_i,
  input wire logic [23:0] pull_dn_i,
  // board side
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_val_i,
  output logic [23:0] pin_level_o
);
  logic flt_r = 1'b0;
  always @(posedge clk_sys_i) begin
    flt_r <= ~flt_r;
  end
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i) |
    (~pin_oe_i & ~ext_en_i & pull_en_i & ~pull_dn_i) |
    (~pin_oe_i & ~ext_en_i & ~pull_en_i & {24{flt_r}});
endmodule // gpgi_pins_model

// file: bench/gpgi_port_bench.sv
// Purpose: self-checking bench of gpgi_port
// Assumes: zero-wait bus slave, board modelled by gpgi_pins_model
// Notes: rows cover register paths; interrupts and reset are hand-written
`timescale 1ns/1ps
module gpgi_port_bench;
  import gpgi_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = HSIZE_WORD;
  logic [31:0] hwdata_i = 32'h0;
  logic [23:0] periph_out_i = 24'h0;
  logic [23:0] periph_oe_i = 24'h000100;
  logic [23:0] ext_en = 24'hFFFFFF;
  logic [23:0] ext_val = 24'hA5C3FF;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, irq_a_o, irq_b_o, wake_o;
  logic [23:0] pin_in_i, pin_out_o, pin_oe_o, pin_ie_o, pin_pullen_o, pin_pulldn_o;
  logic [23:0] pin_slew_o, pin_hidrive_o;
  wire hready_i = hreadyout_o;
  int err_total = 0;
  int n_compared = 0;
  // write address, write data, read address, expected read
  localparam logic [31:0] ROWS [11] = '{32'h005500FF, 32'h040F00F5, 32'hA0800075,
    32'h08FF08FF, 32'h38013801, 32'h80038003, 32'h80FF8003, 32'h20012400,
    32'h440110C2, 32'hFCFFFC00, 32'h2C012C01};
  always #25 clk_sys_i = ~clk_sys_i;
  gpgi_port gpgi_port_inst (.*);
  gpgi_pins_model gpgi_pins_model_inst (.clk_sys_i(clk_sys_i), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pull_en_i(pin_pullen_o), .pull_dn_i(pin_pulldn_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(pin_in_i));
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    hsel_i <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  // board changes one pin, then two edges let the detector see it
  task automatic pin(input int n, input logic v);
    @(posedge clk_sys_i);
    ext_val[n] <= v;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    foreach (ROWS[i]) begin
      wr(ROWS[i][31:24], ROWS[i][23:16]);
      bus(ROWS[i][15:8], 1'b0, 8'h00);
      chk({24'h0, ROWS[i][7:0]}, rd, $sformatf("row %0d", i));
    end
    chk(pin_oe_o[18:16], 3'h3, "gang oe");
    chk(pin_out_o[17:16], 2'h3, "gang data");
    chk(pin_hidrive_o[18:16], 3'h3, "gang drive");
    chk(pin_slew_o[18:16], 3'h3, "gang slew");
    chk(pin_pullen_o[7:0], 8'h70, "pull a");
    chk({pin_oe_o[8], pin_out_o[8], pin_ie_o[7]}, 3'h4, "periph analog");
    wr(8'hA8, 8'h02);
    chk(pin_oe_o[17:16], 2'h1, "analog over gang");
    $display("rows done");
    wr(8'h04, 8'h00);
    wr(8'hA0, 8'h00);
    wr(8'h88, 8'h03);
    wr(8'h84, 8'h06);
    pin(0, 1'b0);
    chk(irq_a_o, 1'b1, "edge a0");
    wr(8'h84, 8'h06);
    chk(irq_a_o, 1'b0, "ack");
    pin(1, 1'b0);
    chk(irq_a_o, 1'b0, "blocked edge");
    pin(1, 1'b1);
    pin(0, 1'b1);
    wr(8'h88, 8'h01);
    pin(1, 1'b0);
    chk(irq_a_o, 1'b0, "pin disabled");
    wr(8'h84, 8'h07);
    pin(0, 1'b0);
    wr(8'h84, 8'h07);
    chk(irq_a_o, 1'b1, "level ack held");
    pin(0, 1'b1);
    wr(8'h84, 8'h07);
    chk(irq_a_o, 1'b0, "level ack");
    wr(8'h8C, 8'h01);
    chk(pin_pulldn_o[0], 1'b1, "pull down");
    pin(0, 1'b0);
    wr(8'h84, 8'h06);
    pin(0, 1'b1);
    chk(irq_a_o, 1'b1, "rising a0");
    wr(8'h84, 8'h00);
    chk(irq_a_o, 1'b0, "masked");
    wr(8'h84, 8'h02);
    chk(irq_a_o, 1'b1, "unmasked");
    wr(8'h94, 8'h02);
    wr(8'h90, 8'h06);
    pin(9, 1'b0);
    chk({irq_b_o, wake_o}, 2'h3, "port b");
    $display("interrupts done");
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk(pin_oe_o | pin_pullen_o | pin_slew_o | pin_hidrive_o, 24'h0, "reset pins");
    chk({pin_ie_o, wake_o}, 25'h1FFFFFE, "reset ie");
    wr(8'h80, 8'h01);
    bus(8'h80, 1'b0, 8'h00);
    chk(rd, 32'h1, "gang after reset");
    $display("reset done");
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    err_total++;
    print_verdict;
  end
endmodule // gpgi_port_bench
bind gpgi_port gpgi_port_props gpgi_port_props_inst (.*);
